// file: rtl/mrc_core.sv
// How it works
// [RULE1] return pops the call stack into the program counter and leaves all flags alone.
// [RULE2] return takes two instruction cycles; busy holds the second one.
// [RULE3] sleep clears the watchdog counter and its prescaler to zero.
// [RULE4] sleep clears the active-low power-down flag and sets the active-low time-out flag.
// [RULE5] after sleep the core halts with the oscillator stopped until a wake input.
// [RULE6] subtract-from-literal puts literal minus w into w and updates carry, digit carry, zero.
// [RULE7] xor-literal puts w xor literal into w and updates only zero.
// [RULE8] subtract-register computes f minus w, updates carry, digit carry, zero; dest 0=w, 1=f.
// [RULE9] xor-register computes w xor f and updates zero; dest 0=w, 1=f.
// [RULE10] nibble swap exchanges the nibbles of f into the destination, no flags touched.
// [RULE11] on subtraction, carry and digit carry are set on no borrow and cleared on borrow.
`timescale 1ns/1ps
`default_nettype none
module mrc_core (
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire logic i_valid,
	input wire mrc_pkg::mrc_req_t i_req,
	input wire logic [mrc_pkg::MRC_DATA_W-1:0] i_file_rdata,
	input wire logic i_call,
	input wire logic [mrc_pkg::MRC_PC_W-1:0] i_call_ret,
	input wire logic i_wdt_tick,
	input wire logic i_wake,
	output logic O_BUSY,
	output logic [mrc_pkg::MRC_DATA_W-1:0] O_W,
	output logic O_FILE_WE,
	output logic [mrc_pkg::MRC_ADDR_W-1:0] O_FILE_ADDR,
	output logic [mrc_pkg::MRC_DATA_W-1:0] O_FILE_WDATA,
	output logic O_PC_LOAD,
	output logic [mrc_pkg::MRC_PC_W-1:0] O_PC,
	output mrc_pkg::mrc_status_t O_STATUS,
	output logic [mrc_pkg::MRC_WDT_W-1:0] O_WDT,
	output logic [mrc_pkg::MRC_PRE_W-1:0] O_WDT_PRE,
	output logic O_SLEEP,
	output logic O_OSC_RUN
);
	import mrc_pkg::*;

	// ------------------------------------------------------------
	// decoding and arithmetic
	// ------------------------------------------------------------
	function automatic logic is_op(input mrc_req_t r, input mrc_op_t o);
		return r.op == o;
	endfunction : is_op

	logic [MRC_DATA_W-1:0] w_reg;
	logic [MRC_SP_W-1:0] sp;
	logic ret_pending;
	logic sleeping;
	logic [MRC_PC_W-1:0] stack_top_value;
	wire go = i_valid && !O_BUSY && !sleeping;
	wire op_ret = go && is_op(i_req, MRC_OP_RETURN);
	wire op_sleep = go && is_op(i_req, MRC_OP_SLEEP);
	wire sub_from_literal_op = go && is_op(i_req, MRC_OP_SUB_FROM_LITERAL);
	wire xor_literal_op = go && is_op(i_req, MRC_OP_XOR_LITERAL);
	wire sub_reg_op = go && is_op(i_req, MRC_OP_SUB_REG);
	wire xor_reg_op = go && is_op(i_req, MRC_OP_XOR_REG);
	wire nibble_swap_op = go && is_op(i_req, MRC_OP_NIBBLE_SWAP);
	wire is_sub = sub_from_literal_op || sub_reg_op;
	wire is_xor = xor_literal_op || xor_reg_op;
	wire is_file_op = sub_reg_op || xor_reg_op || nibble_swap_op;
	wire [7:0] opnd = (sub_from_literal_op || xor_literal_op) ? i_req.literal : i_file_rdata;
	// extra bit holds the no-borrow indication
	wire [8:0] diff = {1'b0, opnd} + {1'b0, ~w_reg} + 9'h001; // [RULE6] [RULE8]
	wire [4:0] diff_lo = {1'b0, opnd[3:0]} + {1'b0, ~w_reg[3:0]} + 5'h01; // [RULE11]
	wire [7:0] swapped = {i_file_rdata[MRC_NIB_LO +: 4], i_file_rdata[MRC_NIB_HI +: 4]}; // [RULE10]
	wire [7:0] result = is_sub ? diff[7:0] : (is_xor ? (w_reg ^ opnd) : swapped); // [RULE7] [RULE9]
	wire to_w = sub_from_literal_op || xor_literal_op
		|| (is_file_op && i_req.dest == MRC_DEST_W);
	wire to_f = is_file_op && i_req.dest == MRC_DEST_F;
	wire [MRC_SP_W-1:0] pop_sp = sp - 3'h1;
	wire [MRC_SP_W-1:0] rd_sp = i_call ? sp : pop_sp;

	mrc_stack u_stack (
		.I_CLK(I_CLK),
		.i_we(i_call && !O_BUSY && !sleeping),
		.i_waddr(sp),
		.i_wdata(i_call_ret),
		.i_raddr(rd_sp),
		.o_rdata(stack_top_value)
	);

	// ------------------------------------------------------------
	// working register, file write and stack pointer
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			w_reg <= MRC_W_RESET;
			O_W <= MRC_W_RESET;
			O_FILE_WE <= 1'b0;
			O_FILE_ADDR <= '0;
			O_FILE_WDATA <= '0;
			sp <= '0;
		end else begin
			if (to_w) begin
				w_reg <= result;
				O_W <= result;
			end
			O_FILE_WE <= to_f;
			O_FILE_ADDR <= i_req.addr;
			O_FILE_WDATA <= result;
			if (op_ret) begin
				sp <= pop_sp; // [RULE1]
			end else if (i_call && !O_BUSY && !sleeping) begin
				sp <= sp + 3'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// two-cycle return, stack read lands in the second cycle
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ret_pending <= 1'b0;
			O_BUSY <= 1'b0;
			O_PC_LOAD <= 1'b0;
			O_PC <= '0;
		end else begin
			ret_pending <= op_ret;
			O_BUSY <= op_ret; // [RULE2]
			O_PC_LOAD <= ret_pending;
			if (ret_pending) begin
				O_PC <= stack_top_value; // [RULE1]
			end
		end
	end

	// ------------------------------------------------------------
	// flags, watchdog and sleep
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_STATUS <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
			O_WDT <= MRC_WDT_CLEAR;
			O_WDT_PRE <= MRC_PRE_CLEAR;
			sleeping <= 1'b0;
			O_SLEEP <= 1'b0;
			O_OSC_RUN <= 1'b1;
		end else begin
			if (is_sub) begin
				O_STATUS.carry_flag <= diff[8]; // [RULE11]
				O_STATUS.digit_carry_flag <= diff_lo[4]; // [RULE11]
			end
			if (is_sub || is_xor) begin
				O_STATUS.zero_flag <= (result == 8'h00); // [RULE7] [RULE9]
			end
			if (op_sleep) begin
				O_WDT <= MRC_WDT_CLEAR; // [RULE3]
				O_WDT_PRE <= MRC_PRE_CLEAR; // [RULE3]
				O_STATUS.powerdown_flag_n <= 1'b0; // [RULE4]
				O_STATUS.timeout_flag_n <= 1'b1; // [RULE4]
			end else if (i_wdt_tick && !sleeping) begin
				{O_WDT, O_WDT_PRE} <= {O_WDT, O_WDT_PRE} + 16'h0001;
			end
			if (op_sleep) begin
				sleeping <= 1'b1; // [RULE5]
				O_SLEEP <= 1'b1;
				O_OSC_RUN <= 1'b0;
			end else if (sleeping && i_wake) begin
				sleeping <= 1'b0;
				O_SLEEP <= 1'b0;
				O_OSC_RUN <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_RET_TWO: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE2]
		op_ret |=> O_BUSY ##1 (O_PC_LOAD && !O_BUSY))
		else $error("return did not take two cycles");
	AST_RET_FLAGS: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE1]
		op_ret |=> $stable(O_STATUS))
		else $error("return changed a flag");
	AST_SLEEP_WDT: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE3]
		op_sleep |=> (O_WDT == 8'h00 && O_WDT_PRE == 8'h00))
		else $error("watchdog not cleared by sleep");
	AST_SLEEP_FLAGS: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE4]
		op_sleep |=> (!O_STATUS.powerdown_flag_n && O_STATUS.timeout_flag_n))
		else $error("sleep flags wrong");
	AST_SLEEP_HALT: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE5]
		(op_sleep ##1 !i_wake) |=> (O_SLEEP && !O_OSC_RUN))
		else $error("core not halted after sleep");
	AST_SUBLIT: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE6]
		sub_from_literal_op |=> O_W == 8'($past(i_req.literal) - $past(w_reg)))
		else $error("literal subtract result wrong");
	AST_XORLIT_Z: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE7]
		xor_literal_op |=> (O_STATUS.zero_flag == (O_W == 8'h00))
			&& $stable(O_STATUS.carry_flag) && $stable(O_STATUS.digit_carry_flag))
		else $error("xor literal flags wrong");
	AST_SUBREG_C: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE11]
		sub_reg_op |=> O_STATUS.carry_flag == ($past(i_file_rdata) >= $past(w_reg)))
		else $error("borrow convention wrong");
	AST_SUBREG_F: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE8]
		(sub_reg_op && i_req.dest == MRC_DEST_F) |=> O_FILE_WE && $stable(O_W))
		else $error("sub to file went wrong");
	AST_XORREG: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE9]
		(xor_reg_op && i_req.dest == MRC_DEST_W)
			|=> (O_W == ($past(w_reg) ^ $past(i_file_rdata)) && !O_FILE_WE))
		else $error("xor register result wrong");
	AST_SWAP: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE10]
		nibble_swap_op |=> $stable(O_STATUS)
			&& O_FILE_WDATA == {$past(i_file_rdata[3:0]), $past(i_file_rdata[7:4])})
		else $error("nibble swap wrong");
endmodule : mrc_core
`default_nettype wire

// file: common/mrc_pkg.sv
package mrc_pkg;
	// ------------------------------------------------------------
	// operation select
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MRC_OP_NONE,
		MRC_OP_RETURN,
		MRC_OP_SLEEP,
		MRC_OP_SUB_FROM_LITERAL,
		MRC_OP_XOR_LITERAL,
		MRC_OP_SUB_REG,
		MRC_OP_XOR_REG,
		MRC_OP_NIBBLE_SWAP
	} mrc_op_t;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int MRC_DATA_W = 8;
	localparam int MRC_ADDR_W = 7;
	localparam int MRC_PC_W = 13;
	localparam int MRC_STACK_DEPTH = 8;
	localparam int MRC_SP_W = 3;
	localparam int MRC_WDT_W = 8;
	localparam int MRC_PRE_W = 8;
	localparam logic [7:0] MRC_W_RESET = 8'h00;
	localparam logic [7:0] MRC_WDT_CLEAR = 8'h00;
	localparam logic [7:0] MRC_PRE_CLEAR = 8'h00;
	localparam logic MRC_DEST_W = 1'b0;
	localparam logic MRC_DEST_F = 1'b1;
	localparam int MRC_NIB_LO = 0;
	localparam int MRC_NIB_HI = 4;

	// ------------------------------------------------------------
	// request and result carriers
	// ------------------------------------------------------------
	typedef struct packed {
		mrc_op_t op;
		logic [7:0] literal;
		logic [6:0] addr;
		logic dest;
	} mrc_req_t;

	typedef struct packed {
		logic carry_flag;
		logic digit_carry_flag;
		logic zero_flag;
		logic timeout_flag_n;
		logic powerdown_flag_n;
	} mrc_status_t;
endpackage : mrc_pkg

// file: rtl/mrc_stack.sv
`timescale 1ns/1ps
`default_nettype none
module mrc_stack (
	input wire logic I_CLK,
	input wire logic i_we,
	input wire logic [mrc_pkg::MRC_SP_W-1:0] i_waddr,
	input wire logic [mrc_pkg::MRC_PC_W-1:0] i_wdata,
	input wire logic [mrc_pkg::MRC_SP_W-1:0] i_raddr,
	output logic [mrc_pkg::MRC_PC_W-1:0] o_rdata
);
	import mrc_pkg::*;
	logic [MRC_PC_W-1:0] mem [MRC_STACK_DEPTH];

	always_ff @(posedge I_CLK) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule : mrc_stack
`default_nettype wire

// file: tb/mrc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, act) begin n_compared++; if ((act) !== (exp)) begin fail_count++; \
	$display("mismatch %s expected %h seen %h", nm, exp, act); end end
module mrc_core_tb;
	import mrc_pkg::*;
	logic I_CLK = 1'b0;
	logic I_RST = 1'b1;
	logic i_valid = 1'b0;
	mrc_req_t i_req = '0;
	logic [7:0] i_file_rdata = 8'h00;
	logic i_call = 1'b0;
	logic [12:0] i_call_ret = 13'h0000;
	logic i_wdt_tick = 1'b0;
	logic i_wake = 1'b0;
	logic busy, file_we, pc_load, sleep, osc_run;
	logic [7:0] w, file_wdata, wdt, wdt_pre;
	logic [6:0] file_addr;
	logic [12:0] pc;
	mrc_status_t st;
	wire logic [2:0] cdz = {st.carry_flag, st.digit_carry_flag, st.zero_flag};
	int fail_count = 0;
	int n_compared = 0;
	int k;

	always #10 I_CLK = ~I_CLK;

	mrc_core u_dut (.I_CLK(I_CLK), .I_RST(I_RST), .i_valid(i_valid), .i_req(i_req),
		.i_file_rdata(i_file_rdata), .i_call(i_call), .i_call_ret(i_call_ret),
		.i_wdt_tick(i_wdt_tick), .i_wake(i_wake), .O_BUSY(busy), .O_W(w),
		.O_FILE_WE(file_we), .O_FILE_ADDR(file_addr), .O_FILE_WDATA(file_wdata),
		.O_PC_LOAD(pc_load), .O_PC(pc), .O_STATUS(st), .O_WDT(wdt), .O_WDT_PRE(wdt_pre),
		.O_SLEEP(sleep), .O_OSC_RUN(osc_run));

	// ------------------------------------------------------------
	// one instruction, result sampled just after the clock edge that takes it
	// ------------------------------------------------------------
	task automatic exec(input mrc_op_t o, input logic [7:0] l, input logic [6:0] a,
		input logic d, input logic [7:0] f);
		@(posedge I_CLK);
		i_valid <= 1'b1;
		i_req <= '{op: o, literal: l, addr: a, dest: d};
		i_file_rdata <= f;
		@(posedge I_CLK);
		i_valid <= 1'b0;
		#1;
	endtask : exec

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge I_CLK);
		I_RST <= 1'b0;
		#1;
		`CHK("w_rst", 8'h00, w)
		`CHK("st_rst", 5'b00011, st)
		exec(MRC_OP_XOR_LITERAL, 8'h05, 7'h00, 1'b0, 8'h00);
		exec(MRC_OP_SUB_FROM_LITERAL, 8'h03, 7'h00, 1'b0, 8'h00);
		`CHK("sub_from_literal_op_w", 8'hfe, w)
		`CHK("sub_from_literal_op_borrow", 3'b000, cdz)
		exec(MRC_OP_SUB_FROM_LITERAL, 8'hfe, 7'h00, 1'b0, 8'h00);
		`CHK("sub_from_literal_op_zero", 8'h00, w)
		`CHK("sub_from_literal_op_noborrow", 3'b111, cdz)
		exec(MRC_OP_XOR_LITERAL, 8'h5a, 7'h00, 1'b0, 8'h00);
		`CHK("xor_literal_op_w", 8'h5a, w)
		`CHK("xor_literal_op_flags", 3'b110, cdz)
		exec(MRC_OP_XOR_LITERAL, 8'h4b, 7'h00, 1'b0, 8'h00);
		`CHK("xor_literal_op_w2", 8'h11, w)
		exec(MRC_OP_SUB_REG, 8'h00, 7'h20, MRC_DEST_F, 8'h20);
		`CHK("sub_reg_op_f", {1'b1, 7'h20, 8'h0f, 8'h11}, {file_we, file_addr, file_wdata, w})
		`CHK("sub_reg_op_f_flags", 3'b100, cdz)
		exec(MRC_OP_SUB_REG, 8'h00, 7'h7f, MRC_DEST_W, 8'h10);
		`CHK("sub_reg_op_w", {1'b0, 8'hff}, {file_we, w})
		`CHK("sub_reg_op_w_flags", 3'b000, cdz)
		exec(MRC_OP_XOR_REG, 8'h00, 7'h00, MRC_DEST_F, 8'hff);
		`CHK("xor_reg_op_f", {1'b1, 8'h00, 8'hff}, {file_we, file_wdata, w})
		`CHK("xor_reg_op_f_z", 3'b001, cdz)
		exec(MRC_OP_NIBBLE_SWAP, 8'h00, 7'h01, MRC_DEST_W, 8'h3c);
		`CHK("swap_w", {8'hc3, 3'b001}, {w, cdz})
		exec(MRC_OP_NIBBLE_SWAP, 8'h00, 7'h02, MRC_DEST_F, 8'ha5);
		`CHK("swap_f", {1'b1, 8'h5a, 8'hc3}, {file_we, file_wdata, w})
		@(posedge I_CLK);
		i_call <= 1'b1;
		i_call_ret <= 13'h1abc;
		@(posedge I_CLK);
		i_call <= 1'b0;
		exec(MRC_OP_RETURN, 8'h00, 7'h00, 1'b0, 8'h00);
		`CHK("ret_second", {1'b1, 1'b0}, {busy, pc_load})
		@(posedge I_CLK);
		#1;
		`CHK("ret_pc", {1'b1, 13'h1abc}, {pc_load, pc})
		`CHK("ret_flags", 3'b001, cdz)
		exec(MRC_OP_XOR_REG, 8'h00, 7'h03, MRC_DEST_W, 8'h0f);
		`CHK("xor_reg_op_w", {8'hcc, 3'b000}, {w, cdz})
		@(posedge I_CLK);
		i_wdt_tick <= 1'b1;
		repeat (259) @(posedge I_CLK);
		i_wdt_tick <= 1'b0;
		#1;
		`CHK("wdt_run", 16'h0103, {wdt, wdt_pre})
		exec(MRC_OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00);
		`CHK("wdt_clr", 16'h0000, {wdt, wdt_pre})
		`CHK("to_pd", 2'b10, {st.timeout_flag_n, st.powerdown_flag_n})
		`CHK("asleep", 2'b10, {sleep, osc_run})
		exec(MRC_OP_XOR_LITERAL, 8'hff, 7'h00, 1'b0, 8'h00);
		`CHK("asleep_w", 8'hcc, w)
		@(posedge I_CLK);
		i_wdt_tick <= 1'b1;
		@(posedge I_CLK);
		i_wdt_tick <= 1'b0;
		#1;
		`CHK("asleep_wdt", 16'h0000, {wdt, wdt_pre})
		@(posedge I_CLK);
		i_wake <= 1'b1;
		k = 0;
		while (sleep !== 1'b0 && k < 8) begin
			@(posedge I_CLK);
			#1;
			k++;
		end
		@(posedge I_CLK);
		i_wake <= 1'b0;
		#1;
		`CHK("wake_wait", 1'b0, sleep)
		`CHK("woken", 1'b1, osc_run)
		final_report();
	end
endmodule : mrc_core_tb
`default_nettype wire
